/* xra_regs.svh */
`ifndef XRA_REGS_SVH
`define XRA_REGS_SVH

// ****************************************
// Address map and timing
// ****************************************
`define XRA_ADDR_W 11
`define XRA_DATA_W 32
`define XRA_MGMT_ADDR_W 16
`define XRA_MEM_DEPTH 2048
`define XRA_ADDR_ADAPT_HOLD 16'h0343
`define XRA_ADDR_BG_CAL 11'h542
`define XRA_BIT_CTRL 0
`define XRA_BG_CAL_RESET 32'h00000001
`define XRA_ADAPT_HOLD_RESET 32'h00000000
`define XRA_BUSY_CYCLES 2'h2
`define XRA_MGMT_RD_CYCLES 2'h1
`define XRA_CLK_MHZ_MIN 100
`define XRA_CLK_MHZ_MAX 125

`endif

/* xra_pkg.sv */
package xra_pkg;
	typedef enum logic [4:0]
	{
		XRA_DEV_IDLE = 5'h01,
		XRA_DEV_BUSY = 5'h02,
		XRA_DEV_DONE = 5'h04,
		XRA_DEV_MRD = 5'h08,
		XRA_DEV_MDONE = 5'h10
	} xra_dev_state_t;

	typedef enum logic [6:0]
	{
		XRA_SEQ_IDLE = 7'h01,
		XRA_SEQ_HOLD = 7'h02,
		XRA_SEQ_CAL_OFF = 7'h04,
		XRA_SEQ_ACCESS = 7'h08,
		XRA_SEQ_CAL_ON = 7'h10,
		XRA_SEQ_RELEASE = 7'h20,
		XRA_SEQ_END = 7'h40
	} xra_seq_state_t;
endpackage

/* xra_if.sv */
`timescale 1ns/10ps
`include "xra_regs.svh"

interface xra_if
(
	input wire logic ref_clk,
	input wire logic arst_n
);
	// Reconfiguration port
	logic reconfig_write;
	logic reconfig_read;
	logic [`XRA_ADDR_W-1:0] reconfig_address;
	logic [`XRA_DATA_W-1:0] reconfig_writedata;
	logic [`XRA_DATA_W-1:0] reconfig_readdata;
	logic reconfig_waitrequest;
	// Management port
	logic mgmt_write;
	logic mgmt_read;
	logic [`XRA_MGMT_ADDR_W-1:0] mgmt_address;
	logic [`XRA_DATA_W-1:0] mgmt_writedata;
	logic [`XRA_DATA_W-1:0] mgmt_readdata;
	logic mgmt_readdata_valid;
	logic mgmt_waitrequest;

	modport device
	(
		input ref_clk, arst_n,
		input reconfig_write, reconfig_read, reconfig_address,
		input reconfig_writedata,
		output reconfig_readdata, reconfig_waitrequest,
		input mgmt_write, mgmt_read, mgmt_address, mgmt_writedata,
		output mgmt_readdata, mgmt_readdata_valid, mgmt_waitrequest
	);

	modport master
	(
		input ref_clk, arst_n,
		output reconfig_write, reconfig_read, reconfig_address,
		output reconfig_writedata,
		input reconfig_readdata, reconfig_waitrequest,
		output mgmt_write, mgmt_read, mgmt_address, mgmt_writedata,
		input mgmt_readdata, mgmt_readdata_valid, mgmt_waitrequest
	);
endinterface

/* xra_device.sv */
`timescale 1ns/10ps
`include "xra_regs.svh"

module xra_device
	import xra_pkg::*;
(
	xra_if.device bus,
	output logic adapt_hold,
	output logic bg_cal_en
);
	// ****************************************
	// Register state
	// ****************************************
	logic [`XRA_DATA_W-1:0] mem [`XRA_MEM_DEPTH];
	logic [`XRA_DATA_W-1:0] adapt_reg;
	logic [`XRA_DATA_W-1:0] next_adapt_reg;
	xra_dev_state_t state;
	xra_dev_state_t next_state;
	logic [1:0] cnt;
	logic [1:0] next_cnt;
	logic [`XRA_DATA_W-1:0] rdata;
	logic [`XRA_DATA_W-1:0] next_rdata;
	logic wait_q;
	logic next_wait_q;
	logic [`XRA_DATA_W-1:0] mdata;
	logic [`XRA_DATA_W-1:0] next_mdata;
	logic mvalid;
	logic next_mvalid;
	logic mwait;
	logic next_mwait;
	logic mem_we;
	logic [`XRA_DATA_W-1:0] mem_rd;
	// Reset word held whole so only its control bit is taken
	localparam logic [`XRA_DATA_W-1:0] BG_CAL_RST = `XRA_BG_CAL_RESET;

	// A memory with a full reset would be wide flops; the clear walks
	// would cost time, so only the control bit of the cell at 0x542 is
	// reset, and every other bit reads as written.
	assign mem_rd = (bus.reconfig_address == `XRA_ADDR_BG_CAL) ?
		{mem[bus.reconfig_address][`XRA_DATA_W-1:1], bg_cal_en} :
		mem[bus.reconfig_address];

	// ****************************************
	// Reconfiguration and management ports
	// ****************************************
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_rdata = rdata;
		next_wait_q = wait_q;
		next_adapt_reg = adapt_reg;
		next_mdata = mdata;
		next_mvalid = 1'b0;
		next_mwait = mwait;
		mem_we = 1'b0;
		case (state)
			XRA_DEV_IDLE:
			begin
				if (bus.reconfig_write || bus.reconfig_read)
				begin
					next_state = XRA_DEV_BUSY;
					next_cnt = `XRA_BUSY_CYCLES;
					next_wait_q = 1'b1;
				end
				else if (bus.mgmt_read)
				begin
					next_state = XRA_DEV_MRD;
					next_mwait = 1'b1;
				end
				else if (bus.mgmt_write
					&& bus.mgmt_address == `XRA_ADDR_ADAPT_HOLD)
					next_adapt_reg = bus.mgmt_writedata;
			end
			XRA_DEV_BUSY:
			begin
				if (cnt == 2'h0)
				begin
					// Request is still held by the master here
					next_state = XRA_DEV_DONE;
					next_wait_q = 1'b0;
					// Writes leave the last read word standing
					if (bus.reconfig_read)
						next_rdata = mem_rd;
					mem_we = bus.reconfig_write;
				end
				else
					next_cnt = cnt - 2'h1;
			end
			XRA_DEV_DONE:
			begin
				// Low for the completion cycle only, so a strobe seen
				// while idle is never taken as already finished
				next_state = XRA_DEV_IDLE;
				next_wait_q = 1'b1;
			end
			XRA_DEV_MRD:
			begin
				next_state = XRA_DEV_MDONE;
				next_mwait = 1'b0;
				next_mvalid = 1'b1;
				next_mdata = (bus.mgmt_address == `XRA_ADDR_ADAPT_HOLD) ?
					adapt_reg : {`XRA_DATA_W{1'b0}};
			end
			XRA_DEV_MDONE:
				next_state = XRA_DEV_IDLE;
			default:
				next_state = XRA_DEV_IDLE;
		endcase
	end

	always_ff @(posedge bus.ref_clk or negedge bus.arst_n)
	begin
		if (!bus.arst_n)
		begin
			state <= XRA_DEV_IDLE;
			cnt <= 2'h0;
			rdata <= {`XRA_DATA_W{1'b0}};
			wait_q <= 1'b1;
			adapt_reg <= `XRA_ADAPT_HOLD_RESET;
			mdata <= {`XRA_DATA_W{1'b0}};
			mvalid <= 1'b0;
			mwait <= 1'b0;
			bg_cal_en <= BG_CAL_RST[`XRA_BIT_CTRL];
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			rdata <= next_rdata;
			wait_q <= next_wait_q;
			adapt_reg <= next_adapt_reg;
			mdata <= next_mdata;
			mvalid <= next_mvalid;
			mwait <= next_mwait;
			if (mem_we && bus.reconfig_address == `XRA_ADDR_BG_CAL)
				bg_cal_en <= bus.reconfig_writedata[`XRA_BIT_CTRL];
		end
	end

	always_ff @(posedge bus.ref_clk)
	begin
		if (mem_we)
			mem[bus.reconfig_address] <= bus.reconfig_writedata;
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Reset sets the flop at once, so waitrequest is high in reset
	assign bus.reconfig_waitrequest = wait_q;
	assign bus.reconfig_readdata = rdata;
	assign bus.mgmt_readdata = mdata;
	assign bus.mgmt_readdata_valid = mvalid;
	assign bus.mgmt_waitrequest = mwait;
	assign adapt_hold = adapt_reg[`XRA_BIT_CTRL];
endmodule

/* xra_master.sv */
`timescale 1ns/10ps
`include "xra_regs.svh"

module xra_master
	import xra_pkg::*;
(
	xra_if.master bus,
	input wire logic start,
	input wire logic adapt_trig_en,
	input wire logic has_bg_cal,
	input wire logic acc_write,
	input wire logic [`XRA_ADDR_W-1:0] acc_address,
	input wire logic [`XRA_DATA_W-1:0] acc_writedata,
	output logic busy,
	output logic done,
	output logic [`XRA_DATA_W-1:0] acc_readdata
);
	// ****************************************
	// Sequencer
	// ****************************************
	xra_seq_state_t state;
	xra_seq_state_t next_state;
	logic rw;
	logic next_rw;
	logic rr;
	logic next_rr;
	logic [`XRA_ADDR_W-1:0] ra;
	logic [`XRA_ADDR_W-1:0] next_ra;
	logic [`XRA_DATA_W-1:0] rd;
	logic [`XRA_DATA_W-1:0] next_rd;
	logic mw;
	logic next_mw;
	logic [`XRA_DATA_W-1:0] md;
	logic [`XRA_DATA_W-1:0] next_md;
	logic next_busy;
	logic next_done;
	logic [`XRA_DATA_W-1:0] next_acc_readdata;
	logic rc_done;

	// Request is finished when the device drops waitrequest
	assign rc_done = (rw || rr) && !bus.reconfig_waitrequest;

	function automatic logic [`XRA_DATA_W-1:0] ctrl_word(input logic v);
		ctrl_word = {{(`XRA_DATA_W-1){1'b0}}, v};
	endfunction

	always_comb
	begin
		next_state = state;
		next_rw = rw;
		next_rr = rr;
		next_ra = ra;
		next_rd = rd;
		next_mw = 1'b0;
		next_md = md;
		next_busy = busy;
		next_done = 1'b0;
		next_acc_readdata = acc_readdata;
		case (state)
			XRA_SEQ_IDLE:
				if (start)
				begin
					next_busy = 1'b1;
					if (adapt_trig_en)
					begin
						next_state = XRA_SEQ_HOLD;
						next_mw = 1'b1;
						next_md = ctrl_word(1'b1);
					end
					else
						next_state = XRA_SEQ_HOLD;
				end
			XRA_SEQ_HOLD:
			begin
				// Management writes are never stalled
				if (has_bg_cal)
				begin
					next_state = XRA_SEQ_CAL_OFF;
					next_rw = 1'b1;
					next_ra = `XRA_ADDR_BG_CAL;
					next_rd = ctrl_word(1'b0);
				end
				else
				begin
					next_state = XRA_SEQ_ACCESS;
					next_rw = acc_write;
					next_rr = !acc_write;
					next_ra = acc_address;
					next_rd = acc_writedata;
				end
			end
			XRA_SEQ_CAL_OFF:
				if (rc_done)
				begin
					// Strobe drops for a cycle between steps
					next_state = XRA_SEQ_ACCESS;
					next_rw = 1'b0;
					next_rr = 1'b0;
				end
			XRA_SEQ_ACCESS:
				if (!rw && !rr)
				begin
					next_rw = acc_write;
					next_rr = !acc_write;
					next_ra = acc_address;
					next_rd = acc_writedata;
				end
				else if (rc_done)
				begin
					next_acc_readdata = bus.reconfig_readdata;
					if (has_bg_cal)
					begin
						next_state = XRA_SEQ_CAL_ON;
						next_rw = 1'b0;
						next_rr = 1'b0;
					end
					else
					begin
						next_state = XRA_SEQ_RELEASE;
						next_rw = 1'b0;
						next_rr = 1'b0;
					end
				end
			XRA_SEQ_CAL_ON:
				if (!rw)
				begin
					next_rw = 1'b1;
					next_ra = `XRA_ADDR_BG_CAL;
					next_rd = ctrl_word(1'b1);
				end
				else if (rc_done)
				begin
					next_state = XRA_SEQ_RELEASE;
					next_rw = 1'b0;
				end
			XRA_SEQ_RELEASE:
			begin
				next_state = XRA_SEQ_END;
				next_mw = adapt_trig_en;
				next_md = ctrl_word(1'b0);
			end
			XRA_SEQ_END:
			begin
				next_state = XRA_SEQ_IDLE;
				next_busy = 1'b0;
				next_done = 1'b1;
			end
			default:
				next_state = XRA_SEQ_IDLE;
		endcase
	end

	always_ff @(posedge bus.ref_clk or negedge bus.arst_n)
	begin
		if (!bus.arst_n)
		begin
			state <= XRA_SEQ_IDLE;
			rw <= 1'b0;
			rr <= 1'b0;
			ra <= {`XRA_ADDR_W{1'b0}};
			rd <= {`XRA_DATA_W{1'b0}};
			mw <= 1'b0;
			md <= {`XRA_DATA_W{1'b0}};
			busy <= 1'b0;
			done <= 1'b0;
			acc_readdata <= {`XRA_DATA_W{1'b0}};
		end
		else
		begin
			state <= next_state;
			rw <= next_rw;
			rr <= next_rr;
			ra <= next_ra;
			rd <= next_rd;
			mw <= next_mw;
			md <= next_md;
			busy <= next_busy;
			done <= next_done;
			acc_readdata <= next_acc_readdata;
		end
	end

	assign bus.reconfig_write = rw;
	assign bus.reconfig_read = rr;
	assign bus.reconfig_address = ra;
	assign bus.reconfig_writedata = rd;
	assign bus.mgmt_write = mw;
	assign bus.mgmt_read = 1'b0;
	assign bus.mgmt_address = `XRA_ADDR_ADAPT_HOLD;
	assign bus.mgmt_writedata = md;
endmodule

/* xra_assertions.sv */
`timescale 1ns/10ps
`include "xra_regs.svh"

module xra_assertions
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic reconfig_write,
	input wire logic reconfig_read,
	input wire logic [`XRA_ADDR_W-1:0] reconfig_address,
	input wire logic [`XRA_DATA_W-1:0] reconfig_writedata,
	input wire logic [`XRA_DATA_W-1:0] reconfig_readdata,
	input wire logic reconfig_waitrequest,
	input wire logic mgmt_write,
	input wire logic mgmt_read,
	input wire logic [`XRA_MGMT_ADDR_W-1:0] mgmt_address,
	input wire logic [`XRA_DATA_W-1:0] mgmt_writedata,
	input wire logic [`XRA_DATA_W-1:0] mgmt_readdata,
	input wire logic mgmt_readdata_valid,
	input wire logic mgmt_waitrequest
);
	// ****
	// Helper state
	// ****
	logic req;
	logic fin;
	logic cal_last;
	logic hold_last;
	logic next_cal_last;
	logic next_hold_last;

	assign req = reconfig_write | reconfig_read;
	assign fin = req & ~reconfig_waitrequest;

	// Last values written, so each step must flip its control bit
	always_comb
	begin
		next_cal_last = cal_last;
		next_hold_last = hold_last;
		if (fin && reconfig_write && reconfig_address == `XRA_ADDR_BG_CAL)
			next_cal_last = reconfig_writedata[0];
		if (mgmt_write)
			next_hold_last = mgmt_writedata[0];
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cal_last <= 1'b1;
			hold_last <= 1'b0;
		end
		else
		begin
			cal_last <= next_cal_last;
			hold_last <= next_hold_last;
		end
	end

	// ****
	// Properties
	// ****
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	property p_wait;
		$rose(req) |-> ##4 !reconfig_waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("late completion");

	property p_hold;
		req && reconfig_waitrequest |=> $stable({reconfig_write,
			reconfig_read, reconfig_address, reconfig_writedata});
	endproperty
	a_hold: assert property (p_hold) else $error("request moved");

	property p_drop;
		fin |=> !req;
	endproperty
	a_drop: assert property (p_drop) else $error("strobe kept");

	property p_rdata;
		$changed(reconfig_readdata) |-> reconfig_read && fin;
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data moved");

	property p_mwait;
		mgmt_write |-> !mgmt_waitrequest;
	endproperty
	a_mwait: assert property (p_mwait) else $error("write stalled");

	property p_onedir;
		!(reconfig_write && reconfig_read);
	endproperty
	a_onedir: assert property (p_onedir) else $error("both strobes");

	property p_mhold;
		mgmt_write |-> mgmt_address == `XRA_ADDR_ADAPT_HOLD
			&& mgmt_writedata[0] != hold_last;
	endproperty
	a_mhold: assert property (p_mhold) else $error("bad hold write");

	property p_apart;
		mgmt_write |-> !req;
	endproperty
	a_apart: assert property (p_apart) else $error("ports overlap");

	property p_cal;
		fin && reconfig_write && reconfig_address == `XRA_ADDR_BG_CAL
			|-> reconfig_writedata[0] != cal_last;
	endproperty
	a_cal: assert property (p_cal) else $error("bad cal write");

	c_read: cover property (fin && reconfig_read);
	c_cal: cover property (fin && reconfig_address == `XRA_ADDR_BG_CAL);
	c_mgmt: cover property (mgmt_write && mgmt_writedata[0]);
endmodule

/* tb.sv */
`timescale 1ns/10ps
`include "xra_regs.svh"

module tb;
	typedef struct packed
	{
		logic rd;
		logic [`XRA_DATA_W-1:0] data;
		logic [`XRA_DATA_W-1:0] mask;
	} xra_note_t;

	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic start = 1'b0;
	logic adapt_trig_en = 1'b0;
	logic has_bg_cal = 1'b0;
	logic acc_write = 1'b0;
	logic [`XRA_ADDR_W-1:0] acc_address = 11'h000;
	logic [`XRA_DATA_W-1:0] acc_writedata = 32'h00000000;
	logic busy;
	logic done;
	logic [`XRA_DATA_W-1:0] acc_readdata;
	logic adapt_hold;
	logic bg_cal_en;
	logic [31:0] rnd = 32'h00010FF2;
	int fails = 0;
	int n_compared = 0;
	xra_note_t notes[$];
	xra_note_t note;

	always #5 ref_clk = ~ref_clk;

	xra_if bus(.ref_clk(ref_clk), .arst_n(arst_n));
	xra_device i_xra_device(.bus(bus), .adapt_hold(adapt_hold),
		.bg_cal_en(bg_cal_en));
	xra_master i_xra_master(.bus(bus), .start(start),
		.adapt_trig_en(adapt_trig_en), .has_bg_cal(has_bg_cal),
		.acc_write(acc_write), .acc_address(acc_address),
		.acc_writedata(acc_writedata), .busy(busy), .done(done),
		.acc_readdata(acc_readdata));
	xra_assertions i_xra_assertions(.ref_clk(ref_clk), .arst_n(arst_n),
		.reconfig_write(bus.reconfig_write),
		.reconfig_read(bus.reconfig_read),
		.reconfig_address(bus.reconfig_address),
		.reconfig_writedata(bus.reconfig_writedata),
		.reconfig_readdata(bus.reconfig_readdata),
		.reconfig_waitrequest(bus.reconfig_waitrequest),
		.mgmt_write(bus.mgmt_write), .mgmt_read(bus.mgmt_read),
		.mgmt_address(bus.mgmt_address),
		.mgmt_writedata(bus.mgmt_writedata),
		.mgmt_readdata(bus.mgmt_readdata),
		.mgmt_readdata_valid(bus.mgmt_readdata_valid),
		.mgmt_waitrequest(bus.mgmt_waitrequest));

	// ****
	// Helpers
	// ****
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask

	task automatic summarize();
		$display("compared %0d, mismatched %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// One whole sequence; waits bounded for the done pulse
	task automatic run(input logic te, input logic cal, input logic w,
		input logic [10:0] a, input logic [31:0] d, input logic [31:0] m);
		int k;
		k = 0;
		@(negedge ref_clk);
		adapt_trig_en = te;
		has_bg_cal = cal;
		acc_write = w;
		acc_address = a;
		acc_writedata = d;
		start = 1'b1;
		notes.push_back('{!w, d, m});
		@(negedge ref_clk);
		start = 1'b0;
		while (done !== 1'b1 && k < 300)
		begin
			@(negedge ref_clk);
			k++;
		end
		check(done, 1'b1, "no done");
	endtask

	// ****
	// Result watcher
	// ****
	// Sampled mid-cycle, where registered outputs have settled
	always @(negedge ref_clk)
	begin
		if (arst_n === 1'b1 && done === 1'b1 && notes.size() > 0)
		begin
			note = notes.pop_front();
			if (note.rd)
				check(acc_readdata & note.mask, note.data & note.mask, "rdata");
			check(adapt_hold, 1'b0, "hold left on");
			check(bg_cal_en, 1'b1, "cal left off");
		end
		// Core access must see adaptation parked when adapt_trig_en is set and calibration off when has_bg_cal is set
		if (arst_n === 1'b1 && (bus.reconfig_write || bus.reconfig_read)
			&& bus.reconfig_waitrequest === 1'b0
			&& bus.reconfig_address != `XRA_ADDR_BG_CAL)
			check({adapt_hold, bg_cal_en}, {adapt_trig_en, !has_bg_cal}, "guard");
	end

	initial
	begin
		repeat (5000) @(posedge ref_clk);
		fails++;
		summarize();
	end

	// ****
	// Tests
	// ****
	initial
	begin
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		arst_n = 1'b1;
		// Top address bit kept low so core accesses never hit 0x542
		for (int i = 0; i < 4; i++)
		begin
			rnd = lfsr(rnd);
			run(i[1], i[0], 1'b1, {1'b0, rnd[9:0]}, rnd, 32'hFFFFFFFF);
			run(i[1], i[0], 1'b0, {1'b0, rnd[9:0]}, rnd, 32'hFFFFFFFF);
			$display("test sequence %0d done", i);
		end
		@(negedge ref_clk);
		adapt_trig_en = 1'b1;
		has_bg_cal = 1'b1;
		start = 1'b1;
		@(negedge ref_clk);
		start = 1'b0;
		repeat (10) @(negedge ref_clk);
		arst_n = 1'b0;
		@(negedge ref_clk);
		check(adapt_hold, 1'b0, "hold after reset");
		check(bg_cal_en, 1'b1, "cal after reset");
		check(busy, 1'b0, "busy after reset");
		arst_n = 1'b1;
		run(1'b0, 1'b0, 1'b0, 11'h542, 32'h00000001, 32'h00000001);
		$display("test mid reset done");
		@(negedge ref_clk);
		summarize();
	end
endmodule
